// file: pcfd_pkg.sv
// Package of constants and types for the pulse counter flutter detector.
package pcfd_pkg;

    // Register word offsets on the plain register port.
    localparam logic [3:0] ADDR_MODE   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_MASK   = 4'h2;
    localparam logic [3:0] ADDR_CNTA   = 4'h3;
    localparam logic [3:0] ADDR_CNTB   = 4'h4;
    localparam logic [3:0] ADDR_FLUT   = 4'h5;
    localparam logic [3:0] ADDR_HIST   = 4'h6;

    // Mode register fields.
    localparam int MODE_QUAD_BIT   = 0;
    localparam int MODE_Q2D_BIT    = 1;
    localparam int MODE_STOP_BIT   = 2;
    localparam int MODE_FLTEN_BIT  = 3;
    localparam logic [7:0] MODE_RESET = 8'h00;

    // Status and mask fields.
    localparam int ST_START_BIT = 0;
    localparam int ST_END_BIT   = 1;
    localparam int ST_CNT_BIT   = 2;
    localparam logic [7:0] MASK_RESET = 8'h00;

    // Opposite-input edges that declare flutter.
    localparam logic [2:0] FLUTTER_EDGES = 3'h4;

    localparam int CNT_W = 16;

    typedef struct packed {
        logic rise_a;
        logic fall_a;
        logic rise_b;
        logic fall_b;
    } pcfd_edges_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } pcfd_bus_s;

    typedef enum logic [1:0] {
        PCFD_QUAD,
        PCFD_DUAL,
        PCFD_HALT
    } pcfd_count_e;

endpackage

// file: pcfd_sync_edge.sv
// Two-flop synchroniser and edge finder for one pulse input.
`timescale 1ns/1ps
module pcfd_sync_edge
    import pcfd_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level_o = sync_reg;
    assign rise_o  = sync_reg & ~last_reg;
    assign fall_o  = ~sync_reg & last_reg;
endmodule

// file: pcfd_flut_cnt.sv
// One flutter counter for one reference edge type.
`timescale 1ns/1ps
module pcfd_flut_cnt
    import pcfd_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ref_edge_i,
    input  wire logic opp_edge_i,
    output logic      flutter_o
);
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;

    // The reference edge wins over an opposite edge in the same cycle.
    assign cnt_next = ref_edge_i ? 3'h0 :
                      (opp_edge_i && cnt_reg != FLUTTER_EDGES) ?
                      cnt_reg + 3'h1 : cnt_reg;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 3'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign flutter_o = (cnt_reg == FLUTTER_EDGES);

    count_sat_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cnt_reg <= FLUTTER_EDGES)
        else $error("Flutter counter passed the threshold.");
    ref_clears_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ref_edge_i |=> cnt_reg == 3'h0 && !flutter_o)
        else $error("Reference edge did not clear the counter.");
endmodule

// file: pcfd_top.sv
// Flutter detector with two pulse counters and a register port.
`timescale 1ns/1ps
// Function
// - Flutter detection works in both quadrature and dual counting.
// - Four edge types each have their own flutter counter.
// - Flutter is declared after four opposite-input edges since reference.
// - Reference edge clears its counter; opposite edges increment it.
// - Detected flutter raises an interrupt and a wake-up when enabled.
// - Stop-count setting halts both counters during flutter in quadrature.
// - Quadrature-to-dual setting switches to dual counting on flutter.
// - Quadrature counting returns automatically when flutter ends.
// - Stop-count setting is ignored while quadrature-to-dual is set.
module pcfd_top
    import pcfd_pkg::*;
(
    input  wire logic       MCLK_I,
    input  wire logic       RST_N_I,
    input  wire logic       PULSE_INPUT_A_I,
    input  wire logic       PULSE_INPUT_B_I,
    input  wire logic [3:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    output logic            IRQ_O,
    output logic            WAKE_O,
    output logic            FLUTTER_O
);
    pcfd_bus_s   bus;
    pcfd_edges_s edg;
    pcfd_edges_s flt;
    logic        lvl_a;
    logic        lvl_b;

    logic [7:0]       counter_mode_reg;
    logic [7:0]       status_reg;
    logic [7:0]       status_next;
    logic [7:0]       mask_reg;
    logic [CNT_W-1:0] cnt_a_reg;
    logic [CNT_W-1:0] cnt_a_next;
    logic [CNT_W-1:0] cnt_b_reg;
    logic [CNT_W-1:0] cnt_b_next;
    logic [7:0]       input_history_reg;
    logic [7:0]       rdata_reg;
    logic             irq_reg;
    logic             wake_reg;
    logic             flut_reg;

    assign bus = '{wr: WR_I, rd: RD_I, addr: ADDR_I, wdata: WDATA_I};

    pcfd_sync_edge u_sync_a (
        .clk_i   (MCLK_I),
        .rst_n_i (RST_N_I),
        .pin_i   (PULSE_INPUT_A_I),
        .level_o (lvl_a),
        .rise_o  (edg.rise_a),
        .fall_o  (edg.fall_a)
    );

    pcfd_sync_edge u_sync_b (
        .clk_i   (MCLK_I),
        .rst_n_i (RST_N_I),
        .pin_i   (PULSE_INPUT_B_I),
        .level_o (lvl_b),
        .rise_o  (edg.rise_b),
        .fall_o  (edg.fall_b)
    );

    wire any_a = edg.rise_a | edg.fall_a;
    wire any_b = edg.rise_b | edg.fall_b;

    // One counter per reference edge; the opposite input drives each.
    pcfd_flut_cnt u_fl_ra (
        .clk_i      (MCLK_I),
        .rst_n_i    (RST_N_I),
        .ref_edge_i (edg.rise_a),
        .opp_edge_i (any_b),
        .flutter_o  (flt.rise_a)
    );
    pcfd_flut_cnt u_fl_fa (
        .clk_i      (MCLK_I),
        .rst_n_i    (RST_N_I),
        .ref_edge_i (edg.fall_a),
        .opp_edge_i (any_b),
        .flutter_o  (flt.fall_a)
    );
    pcfd_flut_cnt u_fl_rb (
        .clk_i      (MCLK_I),
        .rst_n_i    (RST_N_I),
        .ref_edge_i (edg.rise_b),
        .opp_edge_i (any_a),
        .flutter_o  (flt.rise_b)
    );
    pcfd_flut_cnt u_fl_fb (
        .clk_i      (MCLK_I),
        .rst_n_i    (RST_N_I),
        .ref_edge_i (edg.fall_b),
        .opp_edge_i (any_a),
        .flutter_o  (flt.fall_b)
    );

    wire flt_en  = counter_mode_reg[MODE_FLTEN_BIT];
    wire quad    = counter_mode_reg[MODE_QUAD_BIT];
    wire q2d     = counter_mode_reg[MODE_Q2D_BIT];
    wire stop_on = counter_mode_reg[MODE_STOP_BIT];
    // Flutter holds until reference edges clear every full counter.
    wire flutter = flt_en & (|flt);
    wire f_start = flutter & ~flut_reg;
    wire f_end   = ~flutter & flut_reg;

    // Counting style chosen from the mode and the live flutter state.
    pcfd_count_e style;
    assign style = !quad ? PCFD_DUAL :
                   (q2d && flutter) ? PCFD_DUAL :
                   (!q2d && stop_on && flutter) ? PCFD_HALT :
                   PCFD_QUAD;

    // Quadrature: any edge counts in the direction the phase gives.
    // Direction a-leads-b goes to counter A, otherwise counter B.
    wire quad_fwd = (any_a & (lvl_a != lvl_b)) | (any_b & (lvl_a == lvl_b));

    always_comb begin
        cnt_a_next = cnt_a_reg;
        cnt_b_next = cnt_b_reg;
        case (style)
            PCFD_DUAL: begin
                if (edg.rise_a) begin
                    cnt_a_next = cnt_a_reg + 1'b1;
                end
                if (edg.rise_b) begin
                    cnt_b_next = cnt_b_reg + 1'b1;
                end
            end
            PCFD_QUAD: begin
                if ((any_a | any_b) && quad_fwd) begin
                    cnt_a_next = cnt_a_reg + 1'b1;
                end else if (any_a | any_b) begin
                    cnt_b_next = cnt_b_reg + 1'b1;
                end
            end
            PCFD_HALT: begin
                cnt_a_next = cnt_a_reg;
            end
            default: begin
                cnt_a_next = cnt_a_reg;
            end
        endcase
    end

    wire rd_status = bus.rd && bus.addr == ADDR_STATUS;
    wire [7:0] events = {5'h0, |{cnt_a_next[CNT_W-1] & ~cnt_a_reg[CNT_W-1],
                                 cnt_b_next[CNT_W-1] & ~cnt_b_reg[CNT_W-1]},
                         f_end, f_start};

    // A new event in the read cycle survives the read-clear.
    assign status_next = (rd_status ? 8'h00 : status_reg) | events;

    wire [7:0] rd_mux =
        bus.addr == ADDR_MODE   ? counter_mode_reg :
        bus.addr == ADDR_STATUS ? status_reg :
        bus.addr == ADDR_MASK   ? mask_reg :
        bus.addr == ADDR_CNTA   ? cnt_a_reg[7:0] :
        bus.addr == ADDR_CNTB   ? cnt_b_reg[7:0] :
        bus.addr == ADDR_FLUT   ? {3'h0, flutter, flt} :
        bus.addr == ADDR_HIST   ? input_history_reg : 8'h00;

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            counter_mode_reg <= MODE_RESET;
            mask_reg         <= MASK_RESET;
        end else if (bus.wr) begin
            if (bus.addr == ADDR_MODE) begin
                counter_mode_reg <= bus.wdata;
            end
            if (bus.addr == ADDR_MASK) begin
                mask_reg <= bus.wdata;
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            cnt_a_reg         <= '0;
            cnt_b_reg         <= '0;
            input_history_reg <= 8'h00;
            status_reg        <= 8'h00;
            flut_reg          <= 1'b0;
        end else begin
            cnt_a_reg  <= cnt_a_next;
            cnt_b_reg  <= cnt_b_next;
            status_reg <= status_next;
            flut_reg   <= flutter;
            if (any_a | any_b) begin
                input_history_reg <= {input_history_reg[5:0], lvl_b, lvl_a};
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            rdata_reg <= 8'h00;
            irq_reg   <= 1'b0;
            wake_reg  <= 1'b0;
        end else begin
            rdata_reg <= bus.rd ? rd_mux : 8'h00;
            irq_reg   <= |(status_next & mask_reg);
            wake_reg  <= flutter;
        end
    end

    assign RDATA_O   = rdata_reg;
    assign IRQ_O     = irq_reg;
    assign WAKE_O    = wake_reg;
    assign FLUTTER_O = flut_reg;

    halt_holds_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        style == PCFD_HALT |=> $stable(cnt_a_reg) && $stable(cnt_b_reg))
        else $error("Counters moved while halted.");
    q2d_no_halt_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        q2d |-> style != PCFD_HALT)
        else $error("Stop setting acted with mode switch set.");
    switch_dual_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        quad && q2d && flutter |-> style == PCFD_DUAL)
        else $error("No switch to dual on flutter.");
    back_quad_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        quad && !flutter |-> style == PCFD_QUAD)
        else $error("Quadrature not restored after flutter.");
    dual_mode_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        !quad |-> style == PCFD_DUAL)
        else $error("Dual mode not used with quadrature off.");
    start_irq_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        f_start && mask_reg[ST_START_BIT] |=> IRQ_O)
        else $error("Flutter start raised no interrupt.");
    wake_follow_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        flutter |=> WAKE_O && FLUTTER_O)
        else $error("Wake-up missing during flutter.");
    four_edges_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        flt_en && !edg.rise_a && $rose(flt.rise_a) |-> $past(any_b))
        else $error("Flutter rose without an opposite edge.");
    end_clear_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        f_end |=> status_reg[ST_END_BIT])
        else $error("Flutter end not recorded.");

    // Read data stand only in the cycle after a read, so idle reads are 0.
    rdata_idle_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        !bus.rd |=> RDATA_O == 8'h00)
        else $error("Read data shown without a read.");
    irq_level_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        IRQ_O == |(status_reg & $past(mask_reg)))
        else $error("Interrupt level disagrees with status.");
    status_clear_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        rd_status && events == 8'h00 |=> status_reg == 8'h00)
        else $error("Status read did not clear.");
    dual_a_inc_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        style == PCFD_DUAL && edg.rise_a |=>
        cnt_a_reg == $past(cnt_a_reg) + 16'h0001)
        else $error("Dual count A missed a rising edge.");
    dual_b_inc_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        style == PCFD_DUAL && edg.rise_b |=>
        cnt_b_reg == $past(cnt_b_reg) + 16'h0001)
        else $error("Dual count B missed a rising edge.");
    quad_moves_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        style == PCFD_QUAD && (any_a | any_b) |=>
        cnt_a_reg != $past(cnt_a_reg) || cnt_b_reg != $past(cnt_b_reg))
        else $error("Quadrature edge not counted.");
    flut_level_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        FLUTTER_O == $past(flutter))
        else $error("Flutter output lags its state.");
    flt_off_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        !flt_en |=> !FLUTTER_O && !WAKE_O)
        else $error("Flutter shown while detection is off.");
    mode_write_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        bus.wr && bus.addr == ADDR_MODE |=>
        counter_mode_reg == $past(bus.wdata))
        else $error("Mode write did not land.");
    hist_shift_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        (any_a | any_b) |=>
        input_history_reg[1:0] == {$past(lvl_b), $past(lvl_a)})
        else $error("History missed an input edge.");

    // The count registers are read through an eight-bit window.
    if (CNT_W < 8) begin : g_width_chk
        $error("Counter width must be at least eight bits.");
    end
endmodule

// file: pcfd_reed_model.sv
// Model of the two reed contacts that drive the pulse inputs.
`timescale 1ns/1ps
module pcfd_reed_model (
    input  wire logic mclk_i,
    output logic      pin_a_o,
    output logic      pin_b_o
);
    initial begin
        pin_a_o = 1'b0;
        pin_b_o = 1'b0;
    end

    // Each contact change is held for at least nine cycles, so the synchroniser
    // and the flutter counters settle before the next change.
    task automatic flip(input bit on_b, input int n);
        repeat (n) begin
            @(posedge mclk_i);
            if (on_b) begin
                pin_b_o <= ~pin_b_o;
            end else begin
                pin_a_o <= ~pin_a_o;
            end
            repeat (8) @(posedge mclk_i);
        end
    endtask
endmodule

// file: pulse_counter_flutter_detect_tb.sv
// Self-checking bench for the pulse counter flutter detector.
`timescale 1ns/1ps
module pulse_counter_flutter_detect_tb;
    import pcfd_pkg::*;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } pcfd_row_s;
    logic       mclk;
    logic       rst_n;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr_s;
    logic       rd_s;
    logic [7:0] rdata;
    logic       irq;
    logic       wake;
    logic       flut;
    logic       pin_a;
    logic       pin_b;
    logic [7:0] rd_val;
    logic [7:0] ca;
    logic [7:0] cb;
    pcfd_row_s  rows [5];
    int         n_errors;
    int         checks_done;
    int         cycles;

    pcfd_reed_model reed_u (.mclk_i(mclk), .pin_a_o(pin_a), .pin_b_o(pin_b));
    pcfd_top dut_u (.MCLK_I(mclk), .RST_N_I(rst_n), .PULSE_INPUT_A_I(pin_a),
        .PULSE_INPUT_B_I(pin_b), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
        .RD_I(rd_s), .RDATA_O(rdata), .IRQ_O(irq), .WAKE_O(wake),
        .FLUTTER_O(flut));

    task automatic complete_run();
        if (n_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge mclk);
        wr_s  <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge mclk);
        rd_s <= 1'b0;
        #1;
        rd_val = rdata;
    endtask

    task automatic counts();
        rd(ADDR_CNTA);
        ca = rd_val;
        rd(ADDR_CNTB);
        cb = rd_val;
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            complete_run();
        end
    end

    initial begin
        rst_n = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr_s = 1'b0;
        rd_s = 1'b0;
        rows[0] = '{ADDR_MODE, 8'h0F, 8'h0F};
        rows[1] = '{ADDR_MASK, 8'h07, 8'h07};
        rows[2] = '{4'hF, 8'hFF, 8'h00};
        rows[3] = '{ADDR_MODE, 8'h00, MODE_RESET};
        rows[4] = '{ADDR_MASK, 8'h00, MASK_RESET};
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        chk("outputs after reset", 8'h00, {5'h00, irq, wake, flut});
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr);
            chk("register readback", rows[i].exp, rd_val);
        end
        // Quadrature with stop on flutter, flutter enabled, no mask.
        wr(ADDR_MODE, 8'h0D);
        reed_u.flip(1'b0, 1);
        reed_u.flip(1'b1, 1);
        counts();
        chk("quadrature count a", 8'h02, ca);
        reed_u.flip(1'b1, 4);
        chk("flutter level", 8'h01, {7'h00, flut});
        chk("wake level", 8'h01, {7'h00, wake});
        chk("masked irq", 8'h00, {7'h00, irq});
        rd(ADDR_FLUT);
        chk("flutter edges", 8'h1C, rd_val);
        counts();
        reed_u.flip(1'b1, 2);
        rd(ADDR_CNTA);
        chk("halted count a", ca, rd_val);
        rd(ADDR_CNTB);
        chk("halted count b", cb, rd_val);
        wr(ADDR_MASK, 8'h03);
        @(posedge mclk);
        #1;
        chk("unmasked irq", 8'h01, {7'h00, irq});
        rd(ADDR_STATUS);
        chk("status start", 8'h01, rd_val);
        #1;
        chk("irq after clear", 8'h00, {7'h00, irq});
        reed_u.flip(1'b0, 2);
        chk("flutter ended", 8'h00, {7'h00, flut});
        rd(ADDR_STATUS);
        chk("status end", 8'h02, rd_val);
        @(posedge mclk);
        #1;
        chk("rdata idle", 8'h00, rdata);
        // Quadrature to dual on flutter, stop setting also set.
        wr(ADDR_MODE, 8'h0F);
        reed_u.flip(1'b1, 3);
        chk("three edges", 8'h00, {7'h00, flut});
        reed_u.flip(1'b1, 1);
        chk("fourth edge", 8'h01, {7'h00, flut});
        counts();
        reed_u.flip(1'b1, 2);
        rd(ADDR_CNTA);
        chk("dual count a", ca, rd_val);
        rd(ADDR_CNTB);
        chk("dual count b", cb + 8'h01, rd_val);
        reed_u.flip(1'b0, 2);
        chk("dual flutter ended", 8'h00, {7'h00, flut});
        counts();
        reed_u.flip(1'b1, 2);
        rd(ADDR_CNTA);
        chk("back to quad a", ca + 8'h01, rd_val);
        rd(ADDR_CNTB);
        chk("back to quad b", cb + 8'h01, rd_val);
        complete_run();
    end
endmodule
